// *** core/display_fetch_pkg.sv ***
// Purpose: shared constants and types for the window and plane fetch block
// Assumes: 32-bit classic Wishbone, one word per register
// Notes: beam horizontal unit is one low-resolution pixel
`default_nettype none
package display_fetch_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] WIN_START_OFS = 8'h00;
  localparam logic [7:0] WIN_STOP_OFS = 8'h04;
  localparam logic [7:0] FET_START_OFS = 8'h08;
  localparam logic [7:0] FET_STOP_OFS = 8'h0C;
  localparam logic [7:0] ODD_MOD_OFS = 8'h10;
  localparam logic [7:0] EVEN_MOD_OFS = 8'h14;
  localparam logic [7:0] CTRL_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  // plane p: high word at 0x40 + 8p, low word at 0x44 + 8p
  localparam logic [1:0] PTR_REGION = 2'h1;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_HIRES_BIT = 0;
  localparam int CTRL_LACE_BIT = 1;
  localparam int CTRL_PLANES_LSB = 4;
  localparam int STAT_WIN_BIT = 0;
  localparam int STAT_FETCH_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [18:0] PTR_RST = 19'h00000;
  // ----------------------------------------------------------------
  // timing, in low-resolution pixels (half colour clocks); word step in bytes
  // ----------------------------------------------------------------
  localparam logic [8:0] H_STOP_OFFSET = 9'h100;
  localparam logic [9:0] LORES_SLOT_PIX = 10'h010;
  localparam logic [9:0] HIRES_SLOT_PIX = 10'h008;
  localparam logic [9:0] LINE_END_PIX = 10'h010;
  localparam int DISP_LAG_PIX = 9;
  localparam logic [18:0] WORD_BYTES = 19'h00002;
  // ----------------------------------------------------------------
  // fetch request carried to the memory side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] plane;
    logic [18:0] addr;
  } fetch_req_t;
endpackage
`default_nettype wire

// *** core/display_window_and_plane_fetch.sv ***
// Purpose: display window gating and bit-plane word fetch sequencer
// Assumes: beam_h_i counts low-res pixels, two per colour clock
// Notes: fetch words leave through a two-entry buffer
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
module display_window_and_plane_fetch #(
  parameter int PLANES = 6,
  parameter int BUF_DEPTH = 2
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // beam position
  input wire logic [8:0] beam_h_i,
  input wire logic [8:0] beam_v_i,
  // display enables
  output logic window_active_o,
  output logic fetch_active_o,
  output logic pixel_shown_o,
  // fetch requests
  output logic fetch_valid_o,
  input wire logic fetch_ready_i,
  output display_fetch_pkg::fetch_req_t fetch_req_o
);
  localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [AW:0] BUF_FULL = (AW + 1)'(BUF_DEPTH);
  localparam logic [AW-1:0] BUF_LAST = AW'(BUF_DEPTH - 1);

  logic [15:0] win_start_r, win_stop_r, fet_start_r, fet_stop_r;
  logic [15:0] odd_mod_r, even_mod_r, ctrl_r;
  logic [18:0] ptr_r [PLANES];
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_data;
  logic bus_req, bus_wr, ptr_hit, ptr_hi;
  logic [2:0] ptr_sel;
  logic hires;
  logic [2:0] plane_cnt;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  assign bus_req = cyc_i & stb_i & ~ack_r;
  assign bus_wr = bus_req & we_i & ce_i;
  assign ptr_sel = adr_i[5:3];
  assign ptr_hi = ~adr_i[2];
  assign ptr_hit = (adr_i[7:6] == display_fetch_pkg::PTR_REGION) && (32'(ptr_sel) < PLANES);
  assign hires = ctrl_r[display_fetch_pkg::CTRL_HIRES_BIT];
  assign plane_cnt = ctrl_r[display_fetch_pkg::CTRL_PLANES_LSB +: 3];
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_start_r <= display_fetch_pkg::REG_RST;
      win_stop_r <= display_fetch_pkg::REG_RST;
      fet_start_r <= display_fetch_pkg::REG_RST;
      fet_stop_r <= display_fetch_pkg::REG_RST;
      odd_mod_r <= display_fetch_pkg::REG_RST;
      even_mod_r <= display_fetch_pkg::REG_RST;
      ctrl_r <= display_fetch_pkg::REG_RST;
    end else if (bus_wr) begin
      case (adr_i)
        display_fetch_pkg::WIN_START_OFS: win_start_r <= merge16(win_start_r, dat_i, sel_i);
        display_fetch_pkg::WIN_STOP_OFS: win_stop_r <= merge16(win_stop_r, dat_i, sel_i);
        display_fetch_pkg::FET_START_OFS: fet_start_r <= merge16(fet_start_r, dat_i, sel_i);
        display_fetch_pkg::FET_STOP_OFS: fet_stop_r <= merge16(fet_stop_r, dat_i, sel_i);
        display_fetch_pkg::ODD_MOD_OFS: odd_mod_r <= merge16(odd_mod_r, dat_i, sel_i);
        display_fetch_pkg::EVEN_MOD_OFS: even_mod_r <= merge16(even_mod_r, dat_i, sel_i);
        display_fetch_pkg::CTRL_OFS: ctrl_r <= merge16(ctrl_r, dat_i, sel_i);
        default: ;
      endcase
    end
  end
  logic win_r, fet_r, buf_full;
  always_comb begin
    rd_data = 32'h00000000;
    case (adr_i)
      display_fetch_pkg::WIN_START_OFS: rd_data = {16'h0000, win_start_r};
      display_fetch_pkg::WIN_STOP_OFS: rd_data = {16'h0000, win_stop_r};
      display_fetch_pkg::FET_START_OFS: rd_data = {16'h0000, fet_start_r};
      display_fetch_pkg::FET_STOP_OFS: rd_data = {16'h0000, fet_stop_r};
      display_fetch_pkg::ODD_MOD_OFS: rd_data = {16'h0000, odd_mod_r};
      display_fetch_pkg::EVEN_MOD_OFS: rd_data = {16'h0000, even_mod_r};
      display_fetch_pkg::CTRL_OFS: rd_data = {16'h0000, ctrl_r};
      display_fetch_pkg::STATUS_OFS: begin
        rd_data[display_fetch_pkg::STAT_WIN_BIT] = win_r;
        rd_data[display_fetch_pkg::STAT_FETCH_BIT] = fet_r;
        rd_data[display_fetch_pkg::STAT_FULL_BIT] = buf_full;
      end
      default: begin
        if (ptr_hit && ptr_hi) begin
          rd_data = {29'h0, ptr_r[ptr_sel][18:16]};
        end else if (ptr_hit) begin
          rd_data = {16'h0000, ptr_r[ptr_sel][15:0]};
        end
      end
    endcase
  end
  // registered ack, one wait state; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else if (ce_i) begin
      ack_r <= bus_req;
      if (bus_req) begin
        dat_r <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // display window compare
  // ----------------------------------------------------------------
  logic [8:0] horiz_window_begin, horiz_window_end, vert_window_begin, vert_window_end;
  logic win_hit;
  logic [8:0] prev_h_r;
  logic new_pix;

  // no scaling for hires or lace
  assign horiz_window_begin = {1'b0, win_start_r[7:0]};
  assign vert_window_begin = {1'b0, win_start_r[15:8]};
  assign horiz_window_end = {1'b0, win_stop_r[7:0]} + display_fetch_pkg::H_STOP_OFFSET;
  // top bit is complement of bit 7
  assign vert_window_end = {~win_stop_r[15], win_stop_r[15:8]};
  // stop is the exclusive lower right corner
  assign win_hit = (beam_h_i >= horiz_window_begin) && (beam_h_i < horiz_window_end) &&
                   (beam_v_i >= vert_window_begin) && (beam_v_i < vert_window_end);
  assign new_pix = beam_h_i != prev_h_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_r <= 1'b0;
      prev_h_r <= 9'h000;
    end else if (ce_i) begin
      win_r <= win_hit;
      prev_h_r <= beam_h_i;
    end
  end
  assign window_active_o = win_r;

  // ----------------------------------------------------------------
  // fetch window and slot timing
  // ----------------------------------------------------------------
  logic [9:0] h10, f_beg, f_end, issue_lim, line_end, rel;
  logic aligned, slot, eol, fet_hit;
  logic [display_fetch_pkg::DISP_LAG_PIX-1:0] lag_r;

  assign h10 = {1'b0, beam_h_i};
  // one fetch step is two low-res pixels
  // fetch units are half the window resolution
  assign f_beg = {1'b0, fet_start_r[7:0], 1'b0};
  assign f_end = {1'b0, fet_stop_r[7:0], 1'b0};
  // hires runs one slot past the stop
  // hires gives 40 words at nominal settings
  assign issue_lim = f_end + (hires ? display_fetch_pkg::HIRES_SLOT_PIX : 10'h000);
  assign line_end = f_end + display_fetch_pkg::LINE_END_PIX;
  assign rel = h10 - f_beg;
  // slots repeat from the aligned fetch start
  assign aligned = hires ? (rel[2:0] == 3'h0) : (rel[3:0] == 4'h0);
  assign fet_hit = (h10 >= f_beg) && (h10 < line_end);
  assign slot = ce_i && new_pix && (h10 >= f_beg) && (h10 <= issue_lim) && aligned;
  assign eol = ce_i && new_pix && (h10 == line_end);

  // shown data lags fetch by nine pixels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fet_r <= 1'b0;
      lag_r <= '0;
    end else if (ce_i) begin
      fet_r <= fet_hit;
      if (new_pix) begin
        lag_r <= {lag_r[display_fetch_pkg::DISP_LAG_PIX-2:0], fet_r};
      end
    end
  end
  assign fetch_active_o = fet_r;
  assign pixel_shown_o = lag_r[display_fetch_pkg::DISP_LAG_PIX-1] & win_r;

  // ----------------------------------------------------------------
  // plane scheduling and pointers
  // ----------------------------------------------------------------
  logic [PLANES-1:0] pend_r, active, pick;
  logic [2:0] push_plane;
  logic push, buf_in_ready;
  logic [18:0] odd_ext, even_ext;

  always_comb begin
    pick = '0;
    push_plane = 3'h0;
    for (int i = PLANES - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        pick = '0;
        pick[i] = 1'b1;
        push_plane = 3'(i);
      end
    end
  end
  assign push = ce_i && (|pend_r) && buf_in_ready;

  // a stalled sink holds words back; a slot merges into pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else if (ce_i) begin
      pend_r <= (pend_r & ~(push ? pick : '0)) | (slot ? active : '0);
    end
  end

  assign odd_ext = {{3{odd_mod_r[15]}}, odd_mod_r[15:1], 1'b0};
  assign even_ext = {{3{even_mod_r[15]}}, even_mod_r[15:1], 1'b0};

  for (genvar p = 0; p < PLANES; p++) begin : g_plane
    logic [18:0] step, sum;
    logic [15:0] hi_w, lo_w;
    assign active[p] = 32'(plane_cnt) > p;
    assign hi_w = merge16({13'h0000, ptr_r[p][18:16]}, dat_i, sel_i);
    assign lo_w = merge16(ptr_r[p][15:0], dat_i, sel_i);
    always_comb begin
      step = 19'h00000;
      if (push && push_plane == 3'(p)) begin
        step = display_fetch_pkg::WORD_BYTES;
      end
      // plane 1,3,5 odd modulo; 2,4,6 even
      if (eol) begin
        step = step + ((p % 2 == 0) ? odd_ext : even_ext);
      end
    end
    assign sum = ptr_r[p] + step;
    // bit 0 cleared on every load
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ptr_r[p] <= display_fetch_pkg::PTR_RST;
      end else if (bus_wr && ptr_hit && ptr_sel == 3'(p)) begin
        if (ptr_hi) begin
          ptr_r[p] <= {hi_w[2:0], ptr_r[p][15:1], 1'b0};
        end else begin
          ptr_r[p] <= {ptr_r[p][18:16], lo_w[15:1], 1'b0};
        end
      end else if (ce_i) begin
        ptr_r[p] <= {sum[18:1], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // two-entry request buffer
  // ----------------------------------------------------------------
  display_fetch_pkg::fetch_req_t buf_r [BUF_DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic pop;

  assign buf_full = cnt_r == BUF_FULL;
  assign buf_in_ready = !buf_full;
  assign fetch_valid_o = cnt_r != '0;
  assign fetch_req_o = buf_r[rp_r];
  assign pop = ce_i && fetch_valid_o && fetch_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      buf_r[wp_r] <= '{plane: push_plane, addr: ptr_r[push_plane]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == BUF_LAST) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == BUF_LAST) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_ack_pulse;
    ack_o ##1 (!ack_o || !$past(ce_i));
  endsequence
  a_bus_ack_pulse: assert property (s_bus_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_vert_window_end_top: assert property ((ce_i && !win_stop_r[15] && !beam_v_i[8] &&
                                 beam_v_i >= vert_window_begin &&
                                 beam_h_i >= horiz_window_begin &&
                                 beam_h_i < horiz_window_end) |=> window_active_o)
    else $error("window closed above a low vertical stop");
  a_horiz_window_end_bound: assert property ((ce_i && beam_h_i >= horiz_window_end) |=>
                                   !window_active_o)
    else $error("window open past horizontal stop");
  a_vert_window_end_bound: assert property ((ce_i && beam_v_i >= vert_window_end) |=>
                                   !window_active_o)
    else $error("window open past vertical stop");
  a_fetch_begin: assert property ((ce_i && h10 < f_beg) |=> !fetch_active_o)
    else $error("fetch active before start");
  a_ptr_step: assert property ((push && push_plane == 3'h0 && !eol && !bus_wr) |=>
                                ptr_r[0] == $past(ptr_r[0]) + display_fetch_pkg::WORD_BYTES)
    else $error("plane pointer did not step two bytes");
  a_odd_modulo: assert property ((eol && !(push && push_plane == 3'h0) && !bus_wr) |=>
                                  ptr_r[0] == $past(ptr_r[0]) + $past(odd_ext))
    else $error("odd modulo not added at line end");
  a_even_modulo: assert property ((eol && !(push && push_plane == 3'h1) && !bus_wr) |=>
                                   ptr_r[1] == $past(ptr_r[1]) + $past(even_ext))
    else $error("even modulo not added at line end");
  a_ptr_even: assert property (!ptr_r[0][0] && !ptr_r[PLANES-1][0])
    else $error("plane pointer odd");
  a_buf_hold: assert property ((fetch_valid_o && !fetch_ready_i) |=>
                                fetch_valid_o && $stable(fetch_req_o))
    else $error("stalled request lost or changed");
endmodule // display_window_and_plane_fetch
`default_nettype wire

// *** dv/fetch_sink_model.sv ***
// Purpose: display memory side that takes word fetch requests
// Assumes: ready is made from flops only, one word taken per edge
// Notes: mode 0 prompt, mode 1 ready every other cycle, mode 2 stalls
`default_nettype none
module fetch_sink_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pace control
  input wire logic [1:0] mode_i,
  // fetch stream
  input wire logic fetch_valid_i,
  input wire display_fetch_pkg::fetch_req_t fetch_req_i,
  output logic fetch_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // capture of accepted words
  // ----------------------------------------------------------------
  display_fetch_pkg::fetch_req_t got [0:127];
  logic [31:0] count;
  logic phase_r;

  assign fetch_ready_o = (mode_i == 2'h0) ? 1'b1 : (mode_i == 2'h1) ? phase_r : 1'b0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= 1'b0;
      count <= 32'h0;
    end else begin
      phase_r <= ~phase_r;
      if (fetch_valid_i && fetch_ready_o) begin
        got[count[6:0]] <= fetch_req_i;
        count <= count + 32'h1;
      end
    end
  end
endmodule // fetch_sink_model
`default_nettype wire

// *** dv/display_window_and_plane_fetch_tb_top.sv ***
// Purpose: self-checking bench for window gating and plane fetch
// Assumes: classic single-cycle bus master, beam moved by the bench
// Notes: one plane-fetch partner model stands on the stream side
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module display_window_and_plane_fetch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, fetch_valid_o, fetch_ready_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [8:0] beam_h_i, beam_v_i;
  logic window_active_o, fetch_active_o, pixel_shown_o;
  logic [1:0] mode;
  display_fetch_pkg::fetch_req_t fetch_req_o;
  display_fetch_pkg::fetch_req_t exp_q [0:3];
  int errors, checks, cyc_n, fa_t, ps_t;

  display_window_and_plane_fetch u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .beam_h_i(beam_h_i), .beam_v_i(beam_v_i),
    .window_active_o(window_active_o), .fetch_active_o(fetch_active_o),
    .pixel_shown_o(pixel_shown_o), .fetch_valid_o(fetch_valid_o),
    .fetch_ready_i(fetch_ready_i), .fetch_req_o(fetch_req_o));
  fetch_sink_model u_sink (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode),
    .fetch_valid_i(fetch_valid_o), .fetch_req_i(fetch_req_o), .fetch_ready_o(fetch_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // cycle count, timeout and rise markers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc_n++;
    if (fa_t == 0 && fetch_active_o === 1'b1) fa_t = cyc_n;
    if (ps_t == 0 && pixel_shown_o === 1'b1) ps_t = cyc_n;
    if (cyc_n > 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [15:0] d,
                          output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wb_write(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask
  task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(a, 1'b0, 16'h0000, q);
  endtask
  // ----------------------------------------------------------------
  // beam tasks
  // ----------------------------------------------------------------
  task automatic chk_pos(input logic [8:0] h, input logic [8:0] v, input logic ew,
                         input logic ef);
    @(posedge clk_i);
    beam_h_i <= h;
    beam_v_i <= v;
    repeat (3) @(posedge clk_i);
    `CHK(window_active_o, ew)
    `CHK(fetch_active_o, ef)
    if (!ew) `CHK(pixel_shown_o, 1'b0)
  endtask
  task automatic sweep(input int e);
    for (int h = 0; h <= e; h++) begin
      @(posedge clk_i);
      beam_h_i <= 9'(h);
    end
    repeat (8) @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd, n0;
    {rst_i, ce_i, sel_i} = {1'b1, 1'b1, 4'hF};
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    {beam_h_i, beam_v_i, mode, errors, checks, cyc_n, fa_t, ps_t} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wb_read(8'(i * 4), rd);
      `CHK(rd, 32'h0)
    end
    wb_write(8'h30, 16'hFFFF);
    wb_read(8'h30, rd);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 6; i++) begin
      wb_write(8'(i * 4), 16'h1234 + 16'(i));
      wb_read(8'(i * 4), rd);
      `CHK(rd, {16'h0000, 16'h1234 + 16'(i)})
    end
    wb_write(display_fetch_pkg::FET_START_OFS, 16'h0000);
    wb_write(display_fetch_pkg::FET_STOP_OFS, 16'h0000);
    wb_write(display_fetch_pkg::WIN_START_OFS, 16'h2C81);
    for (int c = 0; c < 2; c++) begin
      wb_write(display_fetch_pkg::CTRL_OFS, c[0] ? 16'h0003 : 16'h0000);
      wb_write(display_fetch_pkg::WIN_STOP_OFS, 16'hF4C1);
      chk_pos(9'h081, 9'h02C, 1'b1, 1'b0);
      chk_pos(9'h080, 9'h02C, 1'b0, 1'b0);
      chk_pos(9'h1C0, 9'h050, 1'b1, 1'b0);
      chk_pos(9'h1C1, 9'h050, 1'b0, 1'b0);
      chk_pos(9'h100, 9'h0F3, 1'b1, 1'b0);
      chk_pos(9'h100, 9'h0F4, 1'b0, 1'b0);
      wb_write(display_fetch_pkg::WIN_STOP_OFS, 16'h2CC1);
      chk_pos(9'h100, 9'h0F4, 1'b1, 1'b0);
      chk_pos(9'h100, 9'h12B, 1'b1, 1'b0);
      chk_pos(9'h100, 9'h12C, 1'b0, 1'b0);
    end
    wb_write(display_fetch_pkg::CTRL_OFS, 16'h0000);
    wb_write(display_fetch_pkg::WIN_START_OFS, 16'h0000);
    wb_write(display_fetch_pkg::WIN_STOP_OFS, 16'hFFFF);
    // two words a line, two planes, sink stalled, no modulo yet
    wb_write(display_fetch_pkg::ODD_MOD_OFS, 16'h0000);
    wb_write(display_fetch_pkg::EVEN_MOD_OFS, 16'h0000);
    wb_write(display_fetch_pkg::FET_START_OFS, 16'h0008);
    wb_write(display_fetch_pkg::FET_STOP_OFS, 16'h0010);
    wb_write(8'h40, 16'h0002);
    wb_write(8'h44, 16'h1000);
    wb_write(8'h48, 16'h0002);
    wb_write(8'h4C, 16'h5000);
    wb_write(display_fetch_pkg::CTRL_OFS, 16'h0020);
    n0 = u_sink.count;
    mode <= 2'h2;
    sweep(64);
    wb_read(display_fetch_pkg::STATUS_OFS, rd);
    `CHK(rd[display_fetch_pkg::STAT_FULL_BIT], 1'b1)
    `CHK(u_sink.count, n0)
    mode <= 2'h0;
    repeat (12) @(posedge clk_i);
    `CHK(u_sink.count, n0 + 32'h4)
    exp_q = '{'{3'h0, 19'h21000}, '{3'h1, 19'h25000}, '{3'h0, 19'h21002}, '{3'h1, 19'h25002}};
    for (int k = 0; k < 4; k++) `CHK(u_sink.got[n0 + 32'(k)], exp_q[k])
    wb_write(display_fetch_pkg::ODD_MOD_OFS, 16'h0004);
    wb_write(display_fetch_pkg::EVEN_MOD_OFS, 16'h0006);
    sweep(64);
    wb_read(8'h44, rd);
    `CHK(rd, 32'h0000100C)
    wb_read(8'h4C, rd);
    `CHK(rd, 32'h0000500E)
    wb_read(8'h40, rd);
    `CHK(rd, 32'h00000002)
    wb_write(8'h44, 16'h1001);
    wb_read(8'h44, rd);
    `CHK(rd, 32'h00001000)
    // full lines, one plane, slow sink
    wb_write(display_fetch_pkg::ODD_MOD_OFS, 16'h0000);
    wb_write(8'h40, 16'h0003);
    wb_write(8'h44, 16'h0000);
    wb_write(display_fetch_pkg::FET_START_OFS, 16'h0038);
    wb_write(display_fetch_pkg::FET_STOP_OFS, 16'h00D0);
    wb_write(display_fetch_pkg::CTRL_OFS, 16'h0010);
    beam_v_i <= 9'h010;
    mode <= 2'h1;
    n0 = u_sink.count;
    fa_t = 0;
    ps_t = 0;
    sweep(448);
    `CHK(u_sink.count - n0, 32'd20)
    `CHK(ps_t - fa_t, 9)
    wb_read(8'h44, rd);
    `CHK(rd, 32'h00000028)
    wb_write(display_fetch_pkg::FET_START_OFS, 16'h003C);
    wb_write(display_fetch_pkg::FET_STOP_OFS, 16'h00D4);
    wb_write(display_fetch_pkg::CTRL_OFS, 16'h0011);
    n0 = u_sink.count;
    sweep(448);
    `CHK(u_sink.count - n0, 32'd40)
    wb_read(8'h44, rd);
    `CHK(rd, 32'h00000078)
    wb_write(display_fetch_pkg::CTRL_OFS, 16'h0000);
    chk_pos(9'h077, 9'h010, 1'b1, 1'b0);
    chk_pos(9'h078, 9'h010, 1'b1, 1'b1);
    chk_pos(9'h1B7, 9'h010, 1'b1, 1'b1);
    chk_pos(9'h1B8, 9'h010, 1'b1, 1'b0);
    give_verdict();
  end
endmodule // display_window_and_plane_fetch_tb_top
`default_nettype wire
